// *** src/fbts_pkg.sv ***
// Package of constants for the fieldbus master timing supervisor.
`default_nettype none
package fbts_pkg;
  // ==========================================================
  // Clock and time base.
  localparam int unsigned CLK_HZ = 200_000_000;  // System clock rate.
  localparam int unsigned STEP_US = 100;  // Interval step in microseconds.
  localparam int unsigned POLL_MS = 1;  // Poll timeout step in milliseconds.
  localparam int unsigned WD_MS = 10;  // Watchdog step in milliseconds.
  localparam int unsigned US_CYC = CLK_HZ / 1_000_000;  // Cycles per microsecond.
  localparam int unsigned STEP_CYC = STEP_US * US_CYC;  // Cycles per 100 us step.
  localparam int unsigned MS_CYC = POLL_MS * 1000 * US_CYC;  // Cycles per ms.
  localparam int unsigned WD_CYC = WD_MS * 1000 * US_CYC;  // Cycles per 10 ms.
  // Prescale divisor at 1.5 Mbps: 200 MHz / 1.5 MHz rounded down.
  localparam logic [15:0] BAUD_DIV_RST = 16'h0085;
  // ==========================================================
  // Register offsets.
  localparam logic [7:0] A_CTRL = 8'h00;  // Option bits.
  localparam logic [7:0] A_TSL = 8'h04;  // Slot time.
  localparam logic [7:0] A_TSDR = 8'h08;  // Min and max station delay.
  localparam logic [7:0] A_TQS = 8'h0C;  // Quiet, setup, gap, HSA.
  localparam logic [7:0] A_TTR = 8'h10;  // Manual token rotation time.
  localparam logic [7:0] A_MSI = 8'h14;  // Minimum slave interval and retry.
  localparam logic [7:0] A_POLL = 8'h18;  // Poll timeout and watchdog.
  localparam logic [7:0] A_BAUD = 8'h1C;  // Baud prescaler divisor.
  localparam logic [7:0] A_EBC = 8'h20;  // Estimated cycle time in 100 us steps.
  localparam logic [7:0] A_STAT = 8'h24;  // Status, write 1 to clear bits 0 and 1.
  localparam logic [7:0] A_TTRE = 8'h28;  // Effective token rotation time.
  localparam logic [7:0] A_WDE = 8'h2C;  // Effective watchdog.
  // ==========================================================
  // Control bit positions.
  localparam int CB_CLR = 0;  // Clear on error.
  localparam int CB_MSICALC = 1;  // Interval from estimate.
  localparam int CB_TTRAUTO = 2;  // Token time from interval.
  localparam int CB_WDAUTO = 3;  // Automatic watchdog.
  localparam logic [3:0] CTRL_RST = 4'hC;  // Token auto and watchdog auto on.
  // ==========================================================
  // Reset values.
  localparam logic [13:0] TSL_RST = 14'h012C;  // 300 bit times.
  localparam logic [9:0] MINSDR_RST = 10'h00B;  // 11 bit times.
  localparam logic [9:0] MAXSDR_RST = 10'h096;  // 150 bit times.
  localparam logic [6:0] TQUI_RST = 7'h00;  // No repeater.
  localparam logic [7:0] TSET_RST = 8'h01;  // One bit time.
  localparam logic [6:0] GAP_RST = 7'h0A;  // Gap factor 10.
  localparam logic [6:0] HSA_RST = 7'h7E;  // Station 126.
  localparam logic [23:0] TTR_RST = 24'h000100;  // Lowest legal value.
  localparam logic [15:0] MSI_RST = 16'h0001;  // One step.
  localparam logic [2:0] RETRY_RST = 3'h1;  // One retry.
  localparam logic [15:0] POLL_RST = 16'h0032;  // 50 ms.
  localparam logic [15:0] WD_RST = 16'h0003;  // 30 ms.
  localparam logic [15:0] EBC_RST = 16'h0001;  // One step.
endpackage : fbts_pkg
`default_nettype wire

// *** src/fbts_tick.sv ***
// Programmable divider that emits a one-cycle tick.
`default_nettype none
module fbts_tick (
  input wire logic sys_clk,  // System clock.
  input wire logic rst_n,  // Synchronous reset, active low.
  input wire logic clkEn,  // Freezes state while low.
  input wire logic [23:0] divisor,  // Cycles per tick, zero acts as one.
  output logic tick  // One-cycle pulse each period.
);
  import fbts_pkg::*;
  logic [23:0] count;  // Cycles since last tick.
  wire lastCyc = (count + 24'h000001 >= divisor);  // Period end reached.
  assign tick = clkEn & lastCyc;
  // Counter restarts on each tick.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count <= 24'h000000;
    end else if (clkEn) begin
      count <= lastCyc ? 24'h000000 : count + 24'h000001;
    end
  end
endmodule  // fbts_tick
`default_nettype wire

// *** src/fbts_timer.sv ***
// Down-counting timeout that advances on a tick.
`default_nettype none
module fbts_timer (
  input wire logic sys_clk,  // System clock.
  input wire logic rst_n,  // Synchronous reset, active low.
  input wire logic clkEn,  // Freezes state while low.
  input wire logic start,  // Loads the limit and runs.
  input wire logic stop,  // Cancels a running count.
  input wire logic tick,  // Unit tick.
  input wire logic [23:0] limit,  // Ticks until expiry.
  output logic running,  // Count in progress.
  output logic expired  // One-cycle pulse at expiry.
);
  import fbts_pkg::*;
  logic [23:0] left;  // Ticks remaining.
  wire hitZero = running & tick & (left <= 24'h000001);  // Final tick.
  assign expired = clkEn & hitZero & ~start & ~stop;
  // Start wins over stop; expiry ends the run.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      left <= 24'h000000;
      running <= 1'b0;
    end else if (clkEn) begin
      if (start) begin
        left <= limit;
        running <= 1'b1;
      end else if (stop || hitZero) begin
        running <= 1'b0;
      end else if (running && tick) begin
        left <= left - 24'h000001;
      end
    end
  end
endmodule  // fbts_timer
`default_nettype wire

// *** src/fbts_top.sv ***
// Timing supervisor: bus parameters, response timeouts and retry control.
`default_nettype none
module fbts_top (
  input wire logic sys_clk,  // System clock, 200 MHz.
  input wire logic rst_n,  // Synchronous reset, active low.
  input wire logic clkEn,  // Freezes all state while low.
  input wire logic [7:0] regAddr,  // Register byte address.
  input wire logic [31:0] regWdata,  // Write data.
  input wire logic regWr,  // Write strobe.
  input wire logic regRd,  // Read strobe.
  output logic [31:0] regRdata,  // Read data, one cycle after strobe.
  input wire logic reqSent,  // Request frame to a slave has gone out.
  input wire logic [6:0] reqAddr,  // Slave address of that request.
  input wire logic rspSeen,  // Slave response arrived.
  input wire logic mmReqSent,  // Master-to-master request sent.
  input wire logic mmRspSeen,  // Master-to-master response arrived.
  input wire logic cycleDone,  // Slave polling cycle finished.
  output logic bitTick,  // One pulse per bit time.
  output logic retryReq,  // Pulse: repeat the last request.
  output logic slaveErr,  // Pulse: slave given up.
  output logic [6:0] errAddr,  // Address of the failed slave.
  output logic clearAll,  // Pulse: broadcast clear request.
  output logic mmFail,  // Pulse: master poll timed out.
  output logic pollOk,  // Level: next polling cycle may start.
  output logic addrOk,  // Level: request address within HSA.
  output logic [13:0] slotTime,  // Effective slot time.
  output logic [9:0] minSdr,  // Minimum station delay.
  output logic [9:0] maxSdr,  // Maximum station delay.
  output logic [6:0] quietTime,  // Quiet time.
  output logic [7:0] setupTime,  // Setup time.
  output logic [6:0] gapFactor,  // Gap factor.
  output logic [23:0] ttrEff,  // Effective token rotation time.
  output logic [15:0] wdEff  // Effective slave watchdog, 10 ms units.
);
  import fbts_pkg::*;
  // ==========================================================
  // Configuration registers.
  logic [3:0] ctrl;  // Option bits.
  logic [6:0] hsa;  // Highest station address.
  logic [23:0] ttrMan;  // Manual token time.
  logic [15:0] msiMan;  // Manual minimum slave interval.
  logic [2:0] retryLim;  // Retry limit.
  logic [15:0] pollTo;  // Master poll timeout.
  logic [15:0] wdMan;  // Manual watchdog.
  logic [15:0] baudDiv;  // Bit prescaler.
  logic [15:0] ebc;  // Estimated cycle time, 100 us steps.
  logic [2:0] retryCnt;  // Retries used on current request.
  logic awaiting;  // Slave response pending.
  logic errSticky;  // A slave error has occurred.
  logic mmSticky;  // A master poll has failed.
  wire wrHit = clkEn & regWr;  // Qualified write.
  // Effective minimum slave interval.
  wire [15:0] msiEff = ctrl[CB_MSICALC] ? ebc : msiMan;
  // Interval in bit times: 100 us times bit rate, taken as steps * (cycles / divisor), the division truncated first.
  wire [31:0] stepBits = 32'(STEP_CYC) / {16'h0000, (baudDiv == 16'h0000 ? 16'h0001 : baudDiv)};
  wire [39:0] msiBits = {24'h000000, msiEff} * {8'h00, stepBits};
  wire [23:0] ttrAuto = (msiBits > 40'h0000FFFFFF) ? 24'hFFFFFF : msiBits[23:0];
  assign ttrEff = ctrl[CB_TTRAUTO] ? ttrAuto : ttrMan;
  // Watchdog: five times the interval, so each 100 us step adds a twentieth of a 10 ms unit.
  wire [19:0] wdAuto5 = {4'h0, msiEff} * 20'h00005;
  wire [19:0] wdAutoU = (wdAuto5 + 20'h00063) / 20'h00064;  // Round up to 10 ms.
  wire [15:0] wdAuto = (wdAutoU == 20'h00000) ? 16'h0001 : wdAutoU[15:0];
  assign wdEff = ctrl[CB_WDAUTO] ? wdAuto : wdMan;
  // The time-sync watchdog is absent by design, so no logic exists for it.
  // Slaves keep min and max station delay; the slot timer only covers late answers.
  // Parameter orderings are left to software.
  // ==========================================================
  // Register writes.
  // A write lands on the edge that takes the strobe; unmapped offsets are ignored.
  // Nothing here checks ranges or orderings, so software keeps the values legal.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl <= CTRL_RST;
      slotTime <= TSL_RST;
      minSdr <= MINSDR_RST;
      maxSdr <= MAXSDR_RST;
      quietTime <= TQUI_RST;
      setupTime <= TSET_RST;
      gapFactor <= GAP_RST;
      hsa <= HSA_RST;
      ttrMan <= TTR_RST;
      msiMan <= MSI_RST;
      retryLim <= RETRY_RST;
      pollTo <= POLL_RST;
      wdMan <= WD_RST;
      baudDiv <= BAUD_DIV_RST;
      ebc <= EBC_RST;
    end else if (wrHit) begin
      unique case (regAddr)
        A_CTRL: ctrl <= regWdata[3:0];
        A_TSL: slotTime <= regWdata[13:0];
        A_TSDR: begin
          minSdr <= regWdata[9:0];
          maxSdr <= regWdata[25:16];
        end
        A_TQS: begin
          quietTime <= regWdata[6:0];
          setupTime <= regWdata[15:8];
          gapFactor <= regWdata[22:16];
          hsa <= regWdata[30:24];
        end
        A_TTR: ttrMan <= regWdata[23:0];
        A_MSI: begin
          msiMan <= regWdata[15:0];
          retryLim <= regWdata[18:16];
        end
        A_POLL: begin
          pollTo <= regWdata[15:0];
          wdMan <= regWdata[31:16];
        end
        A_BAUD: baudDiv <= regWdata[15:0];
        A_EBC: ebc <= regWdata[15:0];
        default: ;
      endcase
    end
  end
  // ==========================================================
  // Read mux.
  // Status word: errSticky in bit 0, mmSticky in bit 1, retry count in bits 4 to 2,
  // awaiting in bit 6, pollOk in bit 7 and the failed address in bits 14 to 8.
  wire [31:0] rdMux =
    (regAddr == A_CTRL) ? {28'h0000000, ctrl} :
    (regAddr == A_TSL) ? {18'h00000, slotTime} :
    (regAddr == A_TSDR) ? {6'h00, maxSdr, 6'h00, minSdr} :
    (regAddr == A_TQS) ? {1'b0, hsa, 1'b0, gapFactor, setupTime, 1'b0, quietTime} :
    (regAddr == A_TTR) ? {8'h00, ttrMan} :
    (regAddr == A_MSI) ? {13'h0000, retryLim, msiMan} :
    (regAddr == A_POLL) ? {wdMan, pollTo} :
    (regAddr == A_BAUD) ? {16'h0000, baudDiv} :
    (regAddr == A_EBC) ? {16'h0000, ebc} :
    (regAddr == A_STAT) ? {16'h0000, 1'b0, errAddr, pollOk, awaiting,
                           1'b0, retryCnt, mmSticky, errSticky} :
    (regAddr == A_TTRE) ? {8'h00, ttrEff} :
    (regAddr == A_WDE) ? {16'h0000, wdEff} : 32'h00000000;
  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regRdata <= 32'h00000000;
    end else if (clkEn) begin
      regRdata <= regRd ? rdMux : 32'h00000000;
    end
  end
  // ==========================================================
  // Time bases.
  // All three dividers run free from reset, so a timer started at an arbitrary
  // moment sees its first unit tick anywhere within the first unit.
  logic msTick;  // One per millisecond.
  logic stepTick;  // One per 100 us.
  fbts_tick uBit (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .divisor({8'h00, baudDiv}), .tick(bitTick));
  fbts_tick uMs (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .divisor(24'(MS_CYC)), .tick(msTick));
  fbts_tick uStep (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .divisor(24'(STEP_CYC)), .tick(stepTick));
  // ==========================================================
  // Slot timer and retries.
  // Every request, first try or retry, reloads the slot time; an answer stops it.
  // An expiry either asks for one more try or gives the slave up.
  logic slotExp;  // Slot time passed with no answer.
  logic slotRun;  // Slot timer active.
  fbts_timer uSlot (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .start(reqSent), .stop(rspSeen), .tick(bitTick),
    .limit({10'h000, slotTime}), .running(slotRun), .expired(slotExp));
  assign awaiting = slotRun;
  wire giveUp = slotExp & (retryCnt >= retryLim);
  assign retryReq = slotExp & ~giveUp;
  assign slaveErr = giveUp;
  assign clearAll = giveUp & ctrl[CB_CLR];
  assign addrOk = (reqAddr <= hsa);
  // Retry count and error address tracking.
  // The count clears on any answer, so retries are counted per request.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      retryCnt <= 3'h0;
      errAddr <= 7'h00;
      errSticky <= 1'b0;
    end else if (clkEn) begin
      if (rspSeen || giveUp) begin
        retryCnt <= 3'h0;
      end else if (retryReq) begin
        retryCnt <= retryCnt + 3'h1;
      end
      if (giveUp) begin
        errAddr <= reqAddr;
      end
      if (giveUp) begin
        errSticky <= 1'b1;
      end else if (wrHit && regAddr == A_STAT && regWdata[0]) begin
        errSticky <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Master-to-master poll timeout.
  // The timer runs on the millisecond tick and ends on the partner's answer.
  logic mmExp;  // Timeout pulse.
  fbts_timer uMm (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .start(mmReqSent), .stop(mmRspSeen), .tick(msTick),
    .limit({8'h00, pollTo}), .running(), .expired(mmExp));
  assign mmFail = mmExp;
  // Sticky poll failure, set beats clear.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mmSticky <= 1'b0;
    end else if (clkEn) begin
      if (mmExp) begin
        mmSticky <= 1'b1;
      end else if (wrHit && regAddr == A_STAT && regWdata[1]) begin
        mmSticky <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Minimum slave interval gate.
  // The step divider runs free, so the first step may come at once; one extra
  // step makes the hold-off never shorter than the configured interval.
  logic msiRun;  // Interval still running.
  fbts_timer uMsi (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .start(cycleDone), .stop(1'b0), .tick(stepTick),
    .limit({8'h00, msiEff} + 24'h000001), .running(msiRun), .expired());
  assign pollOk = ~msiRun;
  // ==========================================================
  // Assertions.
  // The final slot expiry of a request, with every retry used up.
  sequence s_give_up;
    slotExp && retryCnt >= retryLim;
  endsequence
  // A request that the slot timer takes.
  sequence s_request;
    clkEn && reqSent;
  endsequence
  // A slave answer that no new request overtakes.
  sequence s_answer;
    clkEn && rspSeen && !reqSent;
  endsequence
  // A give-up broadcasts a clear only when the option is set.
  chk_clear_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
    slaveErr |-> (clearAll == ctrl[CB_CLR]))
    else $error("clear broadcast wrong");
  // The end of a polling cycle holds the next one off.
  chk_interval_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && cycleDone) |=> !pollOk)
    else $error("poll not held off");
  // A held-off cycle is released only on a step tick.
  chk_poll_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!pollOk && !stepTick) |=> !pollOk)
    else $error("poll released between steps");
  // The estimate replaces the manual interval when the option is set.
  chk_msi_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl[CB_MSICALC] |-> msiEff == ebc)
    else $error("interval source wrong");
  // Without the automatic option the manual token time is used.
  chk_ttr_auto: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl[CB_TTRAUTO] |-> ttrEff == ttrMan)
    else $error("manual token time unused");
  // A poll failure never coincides with an answer or a new request.
  chk_mm_fail: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mmFail |-> !mmRspSeen && !mmReqSent)
    else $error("poll fail with answer");
  // A poll failure is remembered for software.
  chk_mm_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mmFail |=> mmSticky)
    else $error("poll failure not kept");
  // Without the automatic option the manual watchdog is used.
  chk_wd_manual: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ctrl[CB_WDAUTO] |-> wdEff == wdMan)
    else $error("manual watchdog unused");
  // The automatic watchdog never collapses to zero.
  chk_wd_auto: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl[CB_WDAUTO] |-> wdEff != 16'h0000)
    else $error("auto watchdog zero");
  // Every request starts the slot timer.
  chk_slot_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_request |=> awaiting)
    else $error("slot timer not started");
  // An answer ends the wait.
  chk_slot_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_answer |=> !awaiting)
    else $error("slot timer not stopped");
  // A give-up reports the slave and restarts the retry count.
  chk_slot_err: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_give_up |-> slaveErr ##1 (retryCnt == 3'h0 && errSticky))
    else $error("no give up");
  // The failed address is the one that was being polled.
  chk_err_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    slaveErr |=> errAddr == $past(reqAddr))
    else $error("failed address wrong");
  // A retry is only asked for while the limit allows it.
  chk_retry_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
    retryReq |-> retryCnt < retryLim)
    else $error("retry beyond limit");
  // Each retry is counted once.
  chk_retry_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
    retryReq |=> retryCnt == $past(retryCnt) + 3'h1)
    else $error("retry not counted");
  // Addresses above the highest station are refused.
  chk_hsa_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    addrOk == (reqAddr <= hsa))
    else $error("address gate wrong");
  // With a divisor above one, bit ticks never come back to back.
  chk_bit_spacing: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bitTick && !wrHit && baudDiv > 16'h0001) |=> !bitTick)
    else $error("bit ticks too close");
endmodule  // fbts_top
`default_nettype wire

// *** tb/fbts_slave_model.sv ***
// Behavioural slave that answers requests after a bounded station delay.
`default_nettype none
module fbts_slave_model (
  input wire logic sys_clk,  // System clock.
  input wire logic reqSent,  // Request went out.
  input wire logic bitTick,  // Bit-time tick.
  input wire logic mute,  // High: never answer.
  input wire logic [9:0] delay,  // Wanted delay in bit times.
  input wire logic [9:0] minSdr,  // Earliest allowed answer.
  input wire logic [9:0] maxSdr,  // Latest allowed answer.
  output logic rspSeen  // One-cycle answer pulse.
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = -1;  // Ticks since the request, -1 while idle.
  logic [9:0] due;  // Delay actually used.
  // A real slave never answers outside its station-delay window.
  assign due = (delay < minSdr) ? minSdr : ((delay > maxSdr) ? maxSdr : delay);
  // Final tick of the wait, unless a new request restarts it.
  wire fire = !reqSent && cnt >= 0 && bitTick && (cnt + 1 >= int'(due));
  // Count bit ticks after a request and answer once, unless muted.
  always @(posedge sys_clk) begin
    rspSeen <= fire && !mute;
    if (reqSent) begin
      cnt <= 0;
    end else if (fire) begin
      cnt <= -1;
    end else if (cnt >= 0 && bitTick) begin
      cnt <= cnt + 1;
    end
  end
endmodule  // fbts_slave_model
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking testbench of the timing supervisor.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fbts_pkg::*;
  logic sys_clk = 0, rst_n = 0, regWr = 0, regRd = 0, go = 0, reqSent = 0, mute = 0;
  logic mmReqSent = 0, mmRspSeen = 0, cycleDone = 0, rspSeen, clkEn = 1;
  logic [7:0] regAddr = 0;
  logic [31:0] regWdata = 0, regRdata, v;
  logic [6:0] reqAddr = 0, errAddr, quietTime, gapFactor;
  logic bitTick, retryReq, slaveErr, clearAll, mmFail, pollOk, addrOk;
  logic [13:0] slotTime;
  logic [9:0] minSdr, maxSdr;
  logic [7:0] setupTime;
  logic [23:0] ttrEff;
  logic [15:0] wdEff;
  int errors = 0, checks = 0, nRetry, nErr, nClr, nMm = 0, nTick = 0, since = 0, gap = 0;
  logic [31:0] expTab [10];  // Reset values in address order.
  fbts_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .reqSent(reqSent), .reqAddr(reqAddr), .rspSeen(rspSeen), .mmReqSent(mmReqSent),
    .mmRspSeen(mmRspSeen), .cycleDone(cycleDone), .bitTick(bitTick), .retryReq(retryReq),
    .slaveErr(slaveErr), .errAddr(errAddr), .clearAll(clearAll), .mmFail(mmFail),
    .pollOk(pollOk), .addrOk(addrOk), .slotTime(slotTime), .minSdr(minSdr),
    .maxSdr(maxSdr), .quietTime(quietTime), .setupTime(setupTime), .gapFactor(gapFactor),
    .ttrEff(ttrEff), .wdEff(wdEff));
  fbts_slave_model slave (.sys_clk(sys_clk), .reqSent(reqSent), .bitTick(bitTick),
    .mute(mute), .delay(10'h005), .minSdr(minSdr), .maxSdr(maxSdr), .rspSeen(rspSeen));
  // ==========================================================
  // Clock, retry echo and event counters.
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // The line master repeats a request whenever the supervisor asks for it.
  always @(posedge sys_clk) reqSent <= go | retryReq;
  // Pulses are counted at the edge where they stand.
  always @(posedge sys_clk) begin
    since = reqSent ? 0 : since + 1;
    if (retryReq && nRetry == 0) gap = since;
    nRetry += int'(retryReq);
    nErr += int'(slaveErr);
    nClr += int'(clearAll);
    nMm += int'(mmFail);
    nTick += int'(bitTick);
  end
  // ==========================================================
  // Bus and comparison tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  // Sends one request and lets the retry sequence run out.
  task automatic poll(input logic m);
    @(posedge sys_clk);
    mute <= m;
    nRetry = 0;
    nErr = 0;
    nClr = 0;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (200) @(posedge sys_clk);
  endtask
  task automatic conclude;
    if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Cuts a hang short; the run needs about 40000 cycles.
  initial begin
    #300000;
    errors++;
    conclude();
  end
  // ==========================================================
  // Test sequence.
  initial begin
    expTab = '{{28'h0, CTRL_RST}, {18'h0, TSL_RST}, {6'h0, MAXSDR_RST, 6'h0, MINSDR_RST},
      {1'b0, HSA_RST, 1'b0, GAP_RST, TSET_RST, 1'b0, TQUI_RST}, {8'h0, TTR_RST},
      {13'h0, RETRY_RST, MSI_RST}, {WD_RST, POLL_RST}, {16'h0, BAUD_DIV_RST},
      {16'h0, EBC_RST}, 32'h0};
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd(8'((i == 9) ? 8'h30 : 4 * i), v);
      chk(v, expTab[i]);
    end
    chk(32'(wdEff), 32'h1);
    wr(8'h1C, 32'h2);
    wr(8'h04, 32'hA);
    wr(8'h08, 32'h0008_0003);
    wr(8'h0C, 32'h0A64_FF02);
    wr(8'h30, 32'hFFFF_FFFF);
    rd(8'h30, v);
    chk(v, 32'h0);
    chk(32'(slotTime), 32'hA);
    chk({12'h0, maxSdr, minSdr}, {12'h0, 10'h8, 10'h3});
    chk({10'h0, quietTime, setupTime, gapFactor}, {10'h0, 7'h2, 8'hFF, 7'h64});
    nTick = 0;
    repeat (40) @(posedge sys_clk);
    #1 chk(nTick, 20);
    chk(32'(ttrEff), 32'h2710);
    wr(8'h10, 32'hFF_FFFF);
    wr(8'h00, 32'h8);
    #1 chk(32'(ttrEff), 32'hFF_FFFF);
    wr(8'h18, 32'hFE01_0001);
    wr(8'h00, 32'h0);
    #1 chk(32'(wdEff), 32'hFE01);
    wr(8'h00, 32'h8);
    wr(8'h14, 32'h0001_0064);
    #1 chk(32'(wdEff), 32'h5);
    wr(8'h20, 32'hC8);
    wr(8'h00, 32'hA);
    #1 chk(32'(wdEff), 32'hA);
    wr(8'h00, 32'h8);
    wr(8'h14, 32'h0001_0001);
    reqAddr <= 7'hA;
    @(posedge sys_clk);
    #1 chk(32'(addrOk), 32'h1);
    @(posedge sys_clk);
    reqAddr <= 7'hB;
    #1 chk(32'(addrOk), 32'h0);
    poll(1'b0);
    chk(nRetry, 0);
    chk(nErr, 0);
    poll(1'b1);
    chk(nRetry, 1);
    chk(nErr, 1);
    chk(nClr, 0);
    chk(32'(gap >= 18 && gap <= 24), 32'h1);
    chk(32'(errAddr), 32'hB);
    rd(8'h24, v);
    chk(32'(v[0]), 32'h1);
    wr(8'h24, 32'h1);
    rd(8'h24, v);
    chk(32'(v[0]), 32'h0);
    wr(8'h00, 32'h9);
    wr(8'h14, 32'h0003_0001);
    poll(1'b1);
    chk(nRetry, 3);
    chk(nErr, 1);
    chk(nClr, 1);
    @(posedge sys_clk);
    mmReqSent <= 1'b1;
    @(posedge sys_clk);
    mmReqSent <= 1'b0;
    repeat (20) @(posedge sys_clk);
    mmRspSeen <= 1'b1;
    @(posedge sys_clk);
    mmRspSeen <= 1'b0;
    cycleDone <= 1'b1;
    @(posedge sys_clk);
    cycleDone <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk(32'(pollOk), 32'h0);
    repeat (19990) @(posedge sys_clk);
    #1 chk(32'(pollOk), 32'h0);
    for (int i = 0; i < 22000 && pollOk !== 1'b1; i++) @(posedge sys_clk);
    #1 chk(32'(pollOk), 32'h1);
    @(posedge sys_clk);
    clkEn <= 1'b0;
    wr(8'h10, 32'h12_3456);
    clkEn <= 1'b1;
    rd(8'h10, v);
    chk(v, 32'hFF_FFFF);
    chk(nMm, 0);
    conclude();
  end
endmodule  // tb
`default_nettype wire
